// *** rtl/sopoh_pkg.sv ***
/*
 * Constants and carrier types for the path overhead processor.
 * Assumes a byte-wide line stream with per-byte slot marking from the framer.
 */
package sopoh_pkg;
  // Register byte offsets
  localparam logic [11:0] SOPOH_CFG_OFF = 12'h000;
  localparam logic [11:0] SOPOH_TRC_OFF = 12'h004;
  localparam logic [11:0] SOPOH_LBL_OFF = 12'h008;
  localparam logic [11:0] SOPOH_RXLBL_OFF = 12'h00C;
  localparam logic [11:0] SOPOH_B3CNT_OFF = 12'h010;
  localparam logic [11:0] SOPOH_FEBECNT_OFF = 12'h014;
  localparam logic [11:0] SOPOH_ISTAT_OFF = 12'h018;
  localparam logic [11:0] SOPOH_IMASK_OFF = 12'h01C;
  localparam logic [11:0] SOPOH_TBUF_OFF = 12'h100;
  localparam logic [11:0] SOPOH_RBUF_OFF = 12'h200;
  // Field positions
  localparam int SOPOH_CFG_SRC = 0;
  localparam int SOPOH_CFG_SHORT = 2;
  localparam int SOPOH_CFG_C2SER = 3;
  localparam int SOPOH_CFG_FEBEREG = 4;
  localparam int SOPOH_CFG_RDIF = 5;
  localparam int SOPOH_CFG_FSINC = 6;
  localparam int SOPOH_CFG_FEBEV = 8;
  localparam int SOPOH_RX_UNST = 8;
  localparam int SOPOH_RX_RDI = 9;
  localparam int SOPOH_G1_FEBE = 4;
  localparam int SOPOH_G1_RDI = 3;
  // Trace sources
  localparam logic [1:0] SOPOH_TSRC_REG = 2'h0;
  localparam logic [1:0] SOPOH_TSRC_SER = 2'h1;
  localparam logic [1:0] SOPOH_TSRC_BUF = 2'h2;
  // Reset values
  localparam logic [7:0] SOPOH_LABEL_RST = 8'h13;
  localparam logic [7:0] SOPOH_TRACE_RST = 8'h00;
  localparam logic [3:0] SOPOH_MASK_RST = 4'h0;
  // Counts, limits and bus response codes
  localparam logic [5:0] SOPOH_TRACE_LAST_LONG = 6'h3F;
  localparam logic [5:0] SOPOH_TRACE_LAST_SHORT = 6'h0F;
  localparam logic [3:0] SOPOH_FEBE_MAX = 4'h8;
  localparam logic [2:0] SOPOH_STABLE_CNT = 3'h5;
  localparam logic [1:0] SOPOH_RESP_OKAY = 2'h0;
  localparam logic [1:0] SOPOH_RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    SLOT_J1 = 2'b00,
    SLOT_B3 = 2'b01,
    SLOT_C2 = 2'b10,
    SLOT_G1 = 2'b11
  } sopoh_slot_t;

  typedef struct packed {
    logic valid;
    logic poh;
    sopoh_slot_t slot;
    logic fstuff;
    logic [7:0] data;
  } sopoh_lane_t;

  typedef struct packed {
    logic awvalid;
    logic [11:0] awaddr;
    logic wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [11:0] araddr;
    logic rready;
  } sopoh_axi_req_t;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } sopoh_axi_rsp_t;
endpackage

// *** rtl/sopoh_core.sv ***
/*
 * Path overhead insert and monitor: trace, parity, label, status bytes.
 * Assumes the framer marks each SPE byte and each overhead slot on both lanes,
 * with J1 first in every frame; serial overhead pins are asynchronous.
 */
// Functional notes
// - Transmit the trace one byte per frame, repeating a 64 or 16 byte string.
// - Trace source is serial input, trace register or buffer; register default, reset zero.
// - Each received trace byte goes out serially and into the receive trace buffer.
// - Transmit parity covers every SPE byte, fixed stuff when enabled, sent next frame.
// - The serial overhead input can flip bits of the transmitted parity byte.
// - Receive parity of a frame is compared with the next frame's byte; mismatches count.
// - The received parity byte goes out on the serial overhead output.
// - Transmit label comes from the label register (reset 0x13) or the serial input.
// - The received label is held in a readable register and sent out serially.
// - A received label that changes between frames is flagged unstable.
// - Remote defect is sent when the request pin or its control bit is set.
// - The far-end error field carries last interval's error count, 0 to 8, or a register.
// - A status byte from the serial input overrides defect and error insertion.
// - Each legal received far-end error value adds to the far-end counter.
// - Received remote defect is detected and the whole status byte goes out serially.
module sopoh_core import sopoh_pkg::*; (
  // Clock and reset
  input wire logic clk_i,
  input wire logic resetn_i,
  // Register bus
  input wire sopoh_axi_req_t axi_req_i,
  output sopoh_axi_rsp_t axi_rsp_o,
  // Transmit line
  input wire sopoh_lane_t tx_lane_i,
  output sopoh_lane_t tx_lane_o,
  // Transmit overhead pins
  input wire logic tx_path_overhead_serial_in_i,
  input wire logic tx_poh_insert_i,
  input wire logic path_defect_request_in_i,
  // Receive line
  input wire sopoh_lane_t rx_lane_i,
  // Receive overhead pins
  output logic rx_path_overhead_serial_out_o,
  output logic rx_poh_start_o,
  output sopoh_slot_t rx_poh_slot_o,
  output logic rx_rdi_o,
  // Interrupt
  output logic irq_o
);

  typedef struct packed {
    logic [2:0] meta;
    logic [2:0] sync;
    logic [7:0] ser_sh;
    logic [1:0] trc_src;
    logic trc_short;
    logic c2_ser;
    logic febe_reg;
    logic rdi_force;
    logic fs_incl;
    logic [3:0] febe_val;
    logic [7:0] trc_reg;
    logic [7:0] lbl_reg;
    logic [63:0][7:0] tbuf;
    logic [63:0][7:0] rbuf;
    logic [5:0] tidx;
    logic [5:0] ridx;
    logic [7:0] tacc;
    logic [7:0] tb3;
    sopoh_lane_t txo;
    logic [7:0] racc;
    logic [7:0] rexp;
    logic rexp_ok;
    logic [3:0] febe_last;
    logic [15:0] b3_cnt;
    logic [15:0] febe_cnt;
    logic [7:0] rlbl;
    logic unstable;
    logic lbl_seen;
    logic [2:0] stab;
    logic rdi;
    logic [7:0] sout;
    logic start;
    sopoh_slot_t slot;
    logic [3:0] ist;
    logic [3:0] imask;
    logic irq;
    logic awr;
    logic aw_full;
    logic [11:0] awa;
    logic wr;
    logic w_full;
    logic [31:0] wd;
    logic [3:0] ws;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } sopoh_state_t;

  sopoh_state_t s_r;
  sopoh_state_t s_nxt;

  logic tj1, tb3, tc2, tg1, rj1, rb3, rc2, rg1, rx_path_overhead_serial_out;
  logic ins, rdi_req, wr_fire, rd_fire, rd_ok, tx_inc, rx_inc;
  logic [5:0] trc_last;
  logic [3:0] bip, febe_tx, ev;
  logic [7:0] pb, tbase, rbase;
  logic [11:0] ra, wa;
  logic [31:0] rd_data;

  function automatic logic [3:0] sopoh_ones(input logic [7:0] v);
    logic [3:0] c;
    c = 4'h0;
    for (int i = 0; i < 8; i++) begin
      c = c + {3'h0, v[i]};
    end
    return c;
  endfunction

  assign tj1 = tx_lane_i.valid && tx_lane_i.poh && tx_lane_i.slot == SLOT_J1;
  assign tb3 = tx_lane_i.valid && tx_lane_i.poh && tx_lane_i.slot == SLOT_B3;
  assign tc2 = tx_lane_i.valid && tx_lane_i.poh && tx_lane_i.slot == SLOT_C2;
  assign tg1 = tx_lane_i.valid && tx_lane_i.poh && tx_lane_i.slot == SLOT_G1;
  assign rx_path_overhead_serial_out = rx_lane_i.valid && rx_lane_i.poh;
  assign rj1 = rx_path_overhead_serial_out && rx_lane_i.slot == SLOT_J1;
  assign rb3 = rx_path_overhead_serial_out && rx_lane_i.slot == SLOT_B3;
  assign rc2 = rx_path_overhead_serial_out && rx_lane_i.slot == SLOT_C2;
  assign rg1 = rx_path_overhead_serial_out && rx_lane_i.slot == SLOT_G1;
  assign ins = s_r.sync[1];
  assign rdi_req = s_r.sync[0] || s_r.rdi_force;
  assign trc_last = s_r.trc_short ? SOPOH_TRACE_LAST_SHORT : SOPOH_TRACE_LAST_LONG;
  assign bip = sopoh_ones(s_r.rexp ^ rx_lane_i.data);
  assign wr_fire = s_r.aw_full && s_r.w_full && !s_r.bvalid;
  assign rd_fire = s_r.arready && axi_req_i.arvalid;
  assign ra = {axi_req_i.araddr[11:2], 2'b00};
  assign wa = {s_r.awa[11:2], 2'b00};

  // Read data decode
  always_comb begin
    rd_data = 32'h0;
    rd_ok = 1'b1;
    if (ra == SOPOH_CFG_OFF) begin
      rd_data[SOPOH_CFG_SRC +: 2] = s_r.trc_src;
      rd_data[SOPOH_CFG_SHORT] = s_r.trc_short;
      rd_data[SOPOH_CFG_C2SER] = s_r.c2_ser;
      rd_data[SOPOH_CFG_FEBEREG] = s_r.febe_reg;
      rd_data[SOPOH_CFG_RDIF] = s_r.rdi_force;
      rd_data[SOPOH_CFG_FSINC] = s_r.fs_incl;
      rd_data[SOPOH_CFG_FEBEV +: 4] = s_r.febe_val;
    end else if (ra == SOPOH_TRC_OFF) begin
      rd_data[7:0] = s_r.trc_reg;
    end else if (ra == SOPOH_LBL_OFF) begin
      rd_data[7:0] = s_r.lbl_reg;
    end else if (ra == SOPOH_RXLBL_OFF) begin
      rd_data[7:0] = s_r.rlbl;
      rd_data[SOPOH_RX_UNST] = s_r.unstable;
      rd_data[SOPOH_RX_RDI] = s_r.rdi;
    end else if (ra == SOPOH_B3CNT_OFF) begin
      rd_data[15:0] = s_r.b3_cnt;
    end else if (ra == SOPOH_FEBECNT_OFF) begin
      rd_data[15:0] = s_r.febe_cnt;
    end else if (ra == SOPOH_ISTAT_OFF) begin
      rd_data[3:0] = s_r.ist;
    end else if (ra == SOPOH_IMASK_OFF) begin
      rd_data[3:0] = s_r.imask;
    end else if (ra[11:8] == SOPOH_TBUF_OFF[11:8]) begin
      rd_data[7:0] = s_r.tbuf[ra[7:2]];
    end else if (ra[11:8] == SOPOH_RBUF_OFF[11:8]) begin
      rd_data[7:0] = s_r.rbuf[ra[7:2]];
    end else begin
      rd_ok = 1'b0;
    end
  end

  always_comb begin
    s_nxt = s_r;
    pb = tx_lane_i.data;
    ev = 4'h0;
    // Pin synchronisers and serial overhead assembly
    s_nxt.meta = {tx_path_overhead_serial_in_i, tx_poh_insert_i, path_defect_request_in_i};
    s_nxt.sync = s_r.meta;
    s_nxt.ser_sh = {s_r.ser_sh[6:0], s_r.sync[2]};

    // Write channel
    if (s_r.awr && axi_req_i.awvalid) begin
      s_nxt.aw_full = 1'b1;
      s_nxt.awa = axi_req_i.awaddr;
    end
    if (s_r.wr && axi_req_i.wvalid) begin
      s_nxt.w_full = 1'b1;
      s_nxt.wd = axi_req_i.wdata;
      s_nxt.ws = axi_req_i.wstrb;
    end
    if (s_r.bvalid && axi_req_i.bready) begin
      s_nxt.bvalid = 1'b0;
    end
    if (wr_fire) begin
      s_nxt.aw_full = 1'b0;
      s_nxt.w_full = 1'b0;
      s_nxt.bvalid = 1'b1;
      s_nxt.bresp = SOPOH_RESP_OKAY;
      if (wa == SOPOH_CFG_OFF) begin
        if (s_r.ws[0]) begin
          s_nxt.trc_src = s_r.wd[SOPOH_CFG_SRC +: 2];
          s_nxt.trc_short = s_r.wd[SOPOH_CFG_SHORT];
          s_nxt.c2_ser = s_r.wd[SOPOH_CFG_C2SER];
          s_nxt.febe_reg = s_r.wd[SOPOH_CFG_FEBEREG];
          s_nxt.rdi_force = s_r.wd[SOPOH_CFG_RDIF];
          s_nxt.fs_incl = s_r.wd[SOPOH_CFG_FSINC];
        end
        if (s_r.ws[1]) begin
          s_nxt.febe_val = s_r.wd[SOPOH_CFG_FEBEV +: 4];
        end
      end else if (wa == SOPOH_TRC_OFF) begin
        if (s_r.ws[0]) begin
          s_nxt.trc_reg = s_r.wd[7:0];
        end
      end else if (wa == SOPOH_LBL_OFF) begin
        if (s_r.ws[0]) begin
          s_nxt.lbl_reg = s_r.wd[7:0];
        end
      end else if (wa == SOPOH_B3CNT_OFF) begin
        s_nxt.b3_cnt = 16'h0;
      end else if (wa == SOPOH_FEBECNT_OFF) begin
        s_nxt.febe_cnt = 16'h0;
      end else if (wa == SOPOH_IMASK_OFF) begin
        if (s_r.ws[0]) begin
          s_nxt.imask = s_r.wd[3:0];
        end
      end else if (wa[11:8] == SOPOH_TBUF_OFF[11:8]) begin
        if (s_r.ws[0]) begin
          s_nxt.tbuf[wa[7:2]] = s_r.wd[7:0];
        end
      end else if (wa == SOPOH_RXLBL_OFF || wa == SOPOH_ISTAT_OFF) begin
        s_nxt.bresp = SOPOH_RESP_OKAY;
      end else if (wa[11:8] == SOPOH_RBUF_OFF[11:8]) begin
        s_nxt.bresp = SOPOH_RESP_OKAY;
      end else begin
        s_nxt.bresp = SOPOH_RESP_SLVERR;
      end
    end
    s_nxt.awr = !s_nxt.aw_full && !s_nxt.bvalid;
    s_nxt.wr = !s_nxt.w_full && !s_nxt.bvalid;

    // Read channel
    if (s_r.rvalid && axi_req_i.rready) begin
      s_nxt.rvalid = 1'b0;
    end
    if (rd_fire) begin
      s_nxt.rvalid = 1'b1;
      s_nxt.rdata = rd_data;
      s_nxt.rresp = rd_ok ? SOPOH_RESP_OKAY : SOPOH_RESP_SLVERR;
    end
    s_nxt.arready = !s_nxt.rvalid;

    // Transmit overhead insertion
    febe_tx = s_r.febe_last;
    if (s_r.febe_reg) begin
      febe_tx = (s_r.febe_val > SOPOH_FEBE_MAX) ? SOPOH_FEBE_MAX : s_r.febe_val;
    end
    if (tj1) begin
      if (s_r.trc_src == SOPOH_TSRC_SER) begin
        pb = s_r.ser_sh;
      end else if (s_r.trc_src == SOPOH_TSRC_BUF) begin
        pb = s_r.tbuf[s_r.tidx];
      end else begin
        pb = s_r.trc_reg;
      end
      s_nxt.tidx = (s_r.tidx >= trc_last) ? 6'h00 : s_r.tidx + 6'h01;
      s_nxt.tb3 = s_r.tacc;
    end else if (tb3) begin
      pb = s_r.tb3 ^ (ins ? s_r.ser_sh : 8'h00);
    end else if (tc2) begin
      pb = s_r.c2_ser ? s_r.ser_sh : s_r.lbl_reg;
    end else if (tg1) begin
      pb = {febe_tx, rdi_req, 3'h0};
      if (ins) begin
        pb = s_r.ser_sh;
      end
    end
    s_nxt.txo = tx_lane_i;
    s_nxt.txo.data = pb;
    tbase = tj1 ? 8'h00 : s_r.tacc;
    tx_inc = tx_lane_i.valid && (!tx_lane_i.fstuff || s_r.fs_incl);
    s_nxt.tacc = tx_inc ? tbase ^ pb : tbase;

    // Receive parity
    rbase = rj1 ? 8'h00 : s_r.racc;
    rx_inc = rx_lane_i.valid && (!rx_lane_i.fstuff || s_r.fs_incl);
    s_nxt.racc = rx_inc ? rbase ^ rx_lane_i.data : rbase;
    if (rj1) begin
      s_nxt.rexp = s_r.racc;
      s_nxt.rexp_ok = 1'b1;
      s_nxt.rbuf[s_r.ridx] = rx_lane_i.data;
      s_nxt.ridx = (s_r.ridx >= trc_last) ? 6'h00 : s_r.ridx + 6'h01;
    end
    if (rb3 && s_r.rexp_ok) begin
      s_nxt.febe_last = bip;
      s_nxt.b3_cnt = s_nxt.b3_cnt + {12'h0, bip};
      ev[0] = bip != 4'h0;
    end
    // Receive label
    if (rc2) begin
      s_nxt.rlbl = rx_lane_i.data;
      s_nxt.lbl_seen = 1'b1;
      if (s_r.lbl_seen && rx_lane_i.data != s_r.rlbl) begin
        s_nxt.unstable = 1'b1;
        s_nxt.stab = 3'h0;
      end else if (s_r.stab >= SOPOH_STABLE_CNT - 3'h1) begin
        s_nxt.unstable = 1'b0;
      end else begin
        s_nxt.stab = s_r.stab + 3'h1;
      end
      ev[1] = s_nxt.unstable != s_r.unstable;
    end
    // Receive status
    if (rg1) begin
      if (rx_lane_i.data[SOPOH_G1_FEBE +: 4] <= SOPOH_FEBE_MAX) begin
        s_nxt.febe_cnt = s_nxt.febe_cnt + {12'h0, rx_lane_i.data[SOPOH_G1_FEBE +: 4]};
        ev[2] = rx_lane_i.data[SOPOH_G1_FEBE +: 4] != 4'h0;
      end
      s_nxt.rdi = rx_lane_i.data[SOPOH_G1_RDI];
      ev[3] = rx_lane_i.data[SOPOH_G1_RDI] != s_r.rdi;
    end
    // Serial overhead output
    s_nxt.start = rx_path_overhead_serial_out;
    if (rx_path_overhead_serial_out) begin
      s_nxt.sout = rx_lane_i.data;
      s_nxt.slot = rx_lane_i.slot;
    end else begin
      s_nxt.sout = {s_r.sout[6:0], 1'b0};
    end

    // Interrupt status, read clears, new events win
    if (rd_fire && ra == SOPOH_ISTAT_OFF) begin
      s_nxt.ist = 4'h0;
    end
    s_nxt.ist = s_nxt.ist | ev;
    s_nxt.irq = |(s_nxt.ist & s_nxt.imask);
  end

  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      s_r <= '0;
      s_r.trc_reg <= SOPOH_TRACE_RST;
      s_r.lbl_reg <= SOPOH_LABEL_RST;
      s_r.imask <= SOPOH_MASK_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign axi_rsp_o = '{awready: s_r.awr, wready: s_r.wr, bvalid: s_r.bvalid,
                       bresp: s_r.bresp, arready: s_r.arready, rvalid: s_r.rvalid,
                       rdata: s_r.rdata, rresp: s_r.rresp};
  assign tx_lane_o = s_r.txo;
  assign rx_path_overhead_serial_out_o = s_r.sout[7];
  assign rx_poh_start_o = s_r.start;
  assign rx_poh_slot_o = s_r.slot;
  assign rx_rdi_o = s_r.rdi;
  assign irq_o = s_r.irq;

  trace_reg_src_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
    tj1 && s_r.trc_src == SOPOH_TSRC_REG |=> tx_lane_o.data == $past(s_r.trc_reg))
    else $error("trace register byte not sent");
  trace_wrap_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
    tj1 && s_r.tidx >= trc_last |=> s_r.tidx == 6'h00)
    else $error("trace index did not wrap");
  parity_send_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
    tb3 && !ins |=> tx_lane_o.data == $past(s_r.tb3))
    else $error("parity byte wrong");
  parity_inject_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
    tb3 && ins |=> tx_lane_o.data == ($past(s_r.tb3) ^ $past(s_r.ser_sh)))
    else $error("parity error mask not applied");
  label_src_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
    tc2 && !s_r.c2_ser |=> tx_lane_o.data == $past(s_r.lbl_reg))
    else $error("label register byte not sent");
  status_override_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
    tg1 && ins |=> tx_lane_o.data == $past(s_r.ser_sh))
    else $error("serial status byte not sent");
  defect_send_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
    tg1 && !ins && rdi_req |=> tx_lane_o.data[SOPOH_G1_RDI])
    else $error("remote defect not sent");
  febe_range_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
    tg1 && !ins |=> tx_lane_o.data[SOPOH_G1_FEBE +: 4] <= SOPOH_FEBE_MAX)
    else $error("far-end field above eight");
  parity_count_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
    rb3 && s_r.rexp_ok && !wr_fire |=> s_r.b3_cnt == $past(s_r.b3_cnt) + $past(bip))
    else $error("parity error count wrong");
  febe_ignore_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
    rg1 && rx_lane_i.data[7:4] > SOPOH_FEBE_MAX && !wr_fire |=> $stable(s_r.febe_cnt))
    else $error("illegal far-end value counted");
  label_capture_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
    rc2 |=> s_r.rlbl == $past(rx_lane_i.data))
    else $error("label not captured");
  label_unstable_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
    rc2 && s_r.lbl_seen && rx_lane_i.data != s_r.rlbl |=> s_r.unstable)
    else $error("label change not flagged");
  serial_out_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
    rx_path_overhead_serial_out ##1 !rx_path_overhead_serial_out |-> rx_path_overhead_serial_out_o == $past(rx_lane_i.data[7])
      ##1 rx_path_overhead_serial_out_o == $past(rx_lane_i.data[6], 2))
    else $error("serial overhead bits wrong");
endmodule

// *** test/sopoh_line_model.sv ***
/*
 * Line-side partner: framed transmit and receive byte streams, 36 bytes a frame.
 * Assumes the core takes one byte per clock; receive content is latched at frame start.
 */
module sopoh_line_model import sopoh_pkg::*; (
  // Clock and reset
  input wire logic clk_i,
  input wire logic resetn_i,
  // Receive frame content
  input wire logic [7:0] c2_i,
  input wire logic [7:0] g1_i,
  input wire logic [7:0] err_i,
  input wire logic [7:0] pay_i,
  // Lanes and frame position
  output sopoh_lane_t tx_lane_o,
  output sopoh_lane_t rx_lane_o,
  output logic [5:0] pos_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] c2_r, g1_r, b3_r, pay_r;
  logic [5:0] quot;
  assign quot = pos_o / 6'h09;
  always @(posedge clk_i) begin
    if (!resetn_i) begin
      pos_o <= 6'h00;
      c2_r <= 8'h13;
      g1_r <= 8'h00;
      b3_r <= 8'h00;
      pay_r <= 8'h00;
    end else begin
      pos_o <= (pos_o == 6'h23) ? 6'h00 : pos_o + 6'h01;
      if (pos_o == 6'h23) begin
        c2_r <= c2_i;
        g1_r <= g1_i;
        // Parity of the ending frame, with injected bit errors
        b3_r <= pay_r ^ err_i;
        pay_r <= pay_i;
      end
    end
  end
  // Overhead bytes xor to zero, so frame parity is the payload byte
  always_comb begin
    tx_lane_o = '0;
    tx_lane_o.valid = 1'b1;
    tx_lane_o.poh = (quot * 6'h09 == pos_o);
    tx_lane_o.slot = sopoh_slot_t'(quot[1:0]);
    rx_lane_o = tx_lane_o;
    case (pos_o)
      6'h00: rx_lane_o.data = b3_r ^ c2_r ^ g1_r;
      6'h04: rx_lane_o.data = pay_r;
      6'h09: rx_lane_o.data = b3_r;
      6'h12: rx_lane_o.data = c2_r;
      6'h1B: rx_lane_o.data = g1_r;
      default: rx_lane_o.data = 8'h00;
    endcase
  end
endmodule

// *** test/test_sonet_path_overhead_proc.sv ***
/*
 * Self-checking bench for the path overhead core over AXI4-Lite and the line lanes.
 * Assumes the line model frames both lanes; serial pins are driven here.
 */
module test_sonet_path_overhead_proc import sopoh_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, resetn, ser, ins, rdi_req, rxs, rxst, rxrdi, irq;
  logic [7:0] c2, g1, err, pay, sh, t;
  logic [7:0] tx_oh [4];
  logic [7:0] rx_sent [4];
  logic [31:0] d;
  logic [1:0] r;
  logic [5:0] pos;
  int i, sh_n, febe_sum, base, bad_count, n_compared;
  sopoh_slot_t sh_slot, rxslot;
  sopoh_axi_req_t req;
  sopoh_axi_rsp_t rsp;
  sopoh_lane_t txi, txo, rxi;

  sopoh_line_model u_line (.clk_i(clk), .resetn_i(resetn), .c2_i(c2), .g1_i(g1),
    .err_i(err), .pay_i(pay), .tx_lane_o(txi), .rx_lane_o(rxi), .pos_o(pos));
  sopoh_core u_dut (.clk_i(clk), .resetn_i(resetn), .axi_req_i(req), .axi_rsp_o(rsp),
    .tx_lane_i(txi), .tx_lane_o(txo), .tx_path_overhead_serial_in_i(ser),
    .tx_poh_insert_i(ins), .path_defect_request_in_i(rdi_req), .rx_lane_i(rxi),
    .rx_path_overhead_serial_out_o(rxs), .rx_poh_start_o(rxst), .rx_poh_slot_o(rxslot),
    .rx_rdi_o(rxrdi), .irq_o(irq));

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  task automatic chk_w(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_b(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task end_of_test;
    $display("compared %0d, mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic hang;
    bad_count++;
    $display("timeout at %0t", $time);
    end_of_test();
  endtask
  task automatic done(input string s);
    $display("test %s finished", s);
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] v);
    int n;
    @(posedge clk);
    req.awvalid <= 1'b1;
    req.awaddr <= a;
    req.wvalid <= 1'b1;
    req.wdata <= v;
    req.wstrb <= 4'hF;
    req.bready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge clk);
      if (rsp.awready) req.awvalid <= 1'b0;
      if (rsp.wready) req.wvalid <= 1'b0;
      if (rsp.bvalid) break;
    end
    req.bready <= 1'b0;
    if (n == 50) hang();
  endtask
  task automatic rd(input logic [11:0] a, output logic [31:0] v, output logic [1:0] rs);
    int n;
    @(posedge clk);
    req.arvalid <= 1'b1;
    req.araddr <= a;
    req.rready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge clk);
      if (rsp.arready) req.arvalid <= 1'b0;
      if (rsp.rvalid) break;
    end
    v = rsp.rdata;
    rs = rsp.rresp;
    req.rready <= 1'b0;
    if (n == 50) hang();
  endtask
  task automatic rdc(input logic [11:0] a, input logic [31:0] m, input logic [31:0] exp);
    rd(a, d, r);
    chk_w(d & m, exp);
    chk_w({30'h0, r}, {30'h0, SOPOH_RESP_OKAY});
  endtask
  task automatic wait_pos(input logic [5:0] p);
    int n;
    for (n = 0; n < 80 && pos !== p; n++) @(posedge clk);
    if (pos !== p) hang();
  endtask
  task automatic frame;
    @(posedge clk);
    wait_pos(6'h00);
    wait_pos(6'h1F);
  endtask
  task automatic rxf(input logic [7:0] c, input logic [7:0] gg, input logic [7:0] e);
    c2 <= c;
    g1 <= gg;
    err <= e;
    frame();
    g1 <= 8'h00;
    err <= 8'h00;
  endtask
  task rst;
    resetn <= 1'b0;
    repeat (6) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
  endtask

  // Overhead capture and serial output check
  always @(posedge clk) begin
    if (!resetn) begin
      sh_n <= 0;
      febe_sum <= 0;
    end else begin
      if (txo.valid && txo.poh) begin
        tx_oh[txo.slot] <= txo.data;
        if (txo.slot == SLOT_G1) febe_sum <= febe_sum + int'(txo.data[7:4]);
      end
      if (rxi.valid && rxi.poh) rx_sent[rxi.slot] <= rxi.data;
      if (sh_n == 8) begin
        chk_b(sh, rx_sent[sh_slot]);
        sh_n <= 0;
      end
      if (rxst) begin
        sh <= {7'h00, rxs};
        sh_n <= 1;
        sh_slot <= rxslot;
      end else if (sh_n > 0 && sh_n < 8) begin
        sh <= {sh[6:0], rxs};
        sh_n <= sh_n + 1;
      end
    end
  end

  initial begin
    resetn = 1'b0;
    ser = 1'b0;
    ins = 1'b0;
    rdi_req = 1'b0;
    req = '0;
    c2 = 8'h13;
    g1 = 8'h00;
    err = 8'h00;
    pay = 8'h5C;
    bad_count = 0;
    n_compared = 0;
    rst();
    rdc(SOPOH_CFG_OFF, 32'hFFFFFFFF, 32'h0);
    rdc(SOPOH_TRC_OFF, 32'hFFFFFFFF, 32'h0);
    rdc(SOPOH_LBL_OFF, 32'hFFFFFFFF, 32'h13);
    rdc(SOPOH_IMASK_OFF, 32'hFFFFFFFF, 32'h0);
    rd(12'h020, d, r);
    chk_w({30'h0, r}, {30'h0, SOPOH_RESP_SLVERR});
    chk_w(d, 32'h0);
    frame();
    chk_b(tx_oh[SLOT_J1], SOPOH_TRACE_RST);
    chk_b(tx_oh[SLOT_C2], SOPOH_LABEL_RST);
    chk_b(tx_oh[SLOT_G1], 8'h00);
    done("reset");
    ser <= 1'b1;
    wr(SOPOH_TRC_OFF, 32'h5A);
    frame();
    chk_b(tx_oh[SLOT_J1], 8'h5A);
    wr(SOPOH_CFG_OFF, 32'h6);
    for (i = 0; i < 16; i++) wr(SOPOH_TBUF_OFF + 12'(4 * i), 32'h40 + i);
    frame();
    t = tx_oh[SLOT_J1];
    chk_b(t & 8'hF0, 8'h40);
    for (i = 1; i <= 16; i++) begin
      d[7:0] = tx_oh[SLOT_J1] ^ tx_oh[SLOT_B3] ^ tx_oh[SLOT_C2] ^ tx_oh[SLOT_G1];
      frame();
      chk_b(tx_oh[SLOT_J1], {4'h4, t[3:0] + 4'(i)});
      chk_b(tx_oh[SLOT_B3], d[7:0]);
    end
    wr(SOPOH_CFG_OFF, 32'h2);
    for (i = 0; i < 64; i++) wr(SOPOH_TBUF_OFF + 12'(4 * i), 32'h0);
    frame();
    chk_b(tx_oh[SLOT_J1], 8'h00);
    wr(SOPOH_CFG_OFF, 32'h9);
    frame();
    chk_b(tx_oh[SLOT_J1], 8'hFF);
    chk_b(tx_oh[SLOT_C2], 8'hFF);
    ins <= 1'b1;
    d[7:0] = tx_oh[SLOT_J1] ^ tx_oh[SLOT_B3] ^ tx_oh[SLOT_C2] ^ tx_oh[SLOT_G1];
    frame();
    chk_b(tx_oh[SLOT_B3], d[7:0] ^ 8'hFF);
    chk_b(tx_oh[SLOT_G1], 8'hFF);
    ser <= 1'b0;
    rdi_req <= 1'b1;
    frame();
    frame();
    chk_b(tx_oh[SLOT_G1], 8'h00);
    chk_b(tx_oh[SLOT_J1], 8'h00);
    ins <= 1'b0;
    frame();
    chk_b(tx_oh[SLOT_G1] & 8'h0F, 8'h08);
    rdi_req <= 1'b0;
    wr(SOPOH_CFG_OFF, 32'h20);
    frame();
    chk_b(tx_oh[SLOT_G1] & 8'h0F, 8'h08);
    wr(SOPOH_CFG_OFF, 32'hB10);
    frame();
    chk_b(tx_oh[SLOT_G1], 8'h80);
    wr(SOPOH_CFG_OFF, 32'h310);
    frame();
    chk_b(tx_oh[SLOT_G1], 8'h30);
    done("transmit");
    rst();
    wr(SOPOH_IMASK_OFF, 32'h1);
    rdc(SOPOH_RBUF_OFF, 32'hFF, 32'h13);
    rxf(8'h13, 8'h00, 8'h00);
    rxf(8'h13, 8'h00, 8'h00);
    rd(SOPOH_ISTAT_OFF, d, r);
    base = febe_sum;
    rxf(8'h13, 8'h00, 8'h81);
    chk_b({7'h00, irq}, 8'h01);
    rdc(SOPOH_B3CNT_OFF, 32'hFFFFFFFF, 32'h2);
    rdc(SOPOH_ISTAT_OFF, 32'h1, 32'h1);
    repeat (2) @(posedge clk);
    chk_b({7'h00, irq}, 8'h00);
    wr(SOPOH_IMASK_OFF, 32'h0);
    rxf(8'h13, 8'h00, 8'hFF);
    chk_b({7'h00, irq}, 8'h00);
    rdc(SOPOH_ISTAT_OFF, 32'h1, 32'h1);
    rdc(SOPOH_B3CNT_OFF, 32'hFFFFFFFF, 32'hA);
    frame();
    chk_w(32'(febe_sum - base), 32'hA);
    wr(SOPOH_B3CNT_OFF, 32'h0);
    rdc(SOPOH_B3CNT_OFF, 32'hFFFFFFFF, 32'h0);
    rxf(8'h13, 8'h50, 8'h00);
    rdc(SOPOH_FEBECNT_OFF, 32'hFFFFFFFF, 32'h5);
    rxf(8'h13, 8'h90, 8'h00);
    rdc(SOPOH_FEBECNT_OFF, 32'hFFFFFFFF, 32'h5);
    rxf(8'h2A, 8'h08, 8'h00);
    chk_b({7'h00, rxrdi}, 8'h01);
    rdc(SOPOH_RXLBL_OFF, 32'h3FF, 32'h32A);
    for (i = 0; i < 7; i++) frame();
    rdc(SOPOH_RXLBL_OFF, 32'h3FF, 32'h2A);
    chk_b({7'h00, rxrdi}, 8'h00);
    done("receive");
    end_of_test();
  end
endmodule
